/* rtl/psr_rst_sync.sv */
/*
 * Reset release synchroniser: asynchronous assert, two-flop release.
 * Assumes the clock runs while reset is released.
 */
`timescale 1ns/1ps
module psr_rst_sync (
    // Clock and raw reset
    input  wire logic i_clk,
    input  wire logic i_nrst,
    // Synchronised reset
    output logic      o_nrst
);
    logic stage1;
    logic stage2;
    logic next_stage1;

    // Next value: shift a one in after release
    always_comb begin
        next_stage1 = 1'b1;
    end

    // Two flops; only stage2 reads stage1
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= stage1;
        end
    end

    assign o_nrst = stage2;
endmodule : psr_rst_sync

/* rtl/psr_soft_reset.sv */
/*
 * Peripheral soft reset control: APB register bank whose set bits hold
 * individual peripherals and general-purpose ports in reset.
 * Assumes a single 50 MHz clock, an APB master and peripherals that take an
 * active-high reset level from the outputs.
 */
// Implementation choice: the APB interface to the registers.
// Summary of operation
// - Port register writes change only bits whose port capability bit is set.
// - Port reset register at 0x048, read/write, resets to all zeros.
// - Port bits 4..0 reset ports E, D, C, B, A; read/write, zero after reset.
// - First register: bits 1,0 serial ports, 4 sync serial, 12 two-wire, 16 timer.
// - Port bits 31:5 read zero, ignore writes; software preserves them.
`timescale 1ns/1ps
module psr_soft_reset #(
    parameter logic [31:0] PORT_CAP = psr_pkg::RST_PORT_CAP
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Peripheral reset levels, active high
    output psr_pkg::psr_periph_rst_t o_periph_rst,
    output logic [4:0]       o_port_rst
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (PORT_CAP[31:psr_pkg::GPIO_PORTS] != '0) begin : g_cap_chk
        $error("PORT_CAP sets bits above the implemented ports");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic nrst;

    psr_rst_sync u_rst_sync (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .o_nrst (nrst)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    psr_pkg::psr_apb_req_t req;
    logic                  access;
    logic                  wr;
    logic                  hit_first;
    logic                  hit_port;
    logic                  hit_cap;

    // Bundle the request and decode the address
    always_comb begin
        req.psel    = i_psel;
        req.penable = i_penable;
        req.pwrite  = i_pwrite;
        req.paddr   = i_paddr;
        req.pwdata  = i_pwdata;
        access      = req.psel && req.penable;
        wr          = access && req.pwrite;
        hit_first   = (req.paddr == psr_pkg::OFS_PERIPH_FIRST);
        hit_port    = (req.paddr == psr_pkg::OFS_GPIO_PORT);
        hit_cap     = (req.paddr == psr_pkg::OFS_PORT_CAP);
    end

    // Zero-wait slave; unmapped addresses flag an error in the access phase
    assign o_pready  = 1'b1;
    assign o_pslverr = access && !(hit_first || hit_port || hit_cap);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [31:0] periph_first;
    logic [31:0] gpio_port_soft_reset;
    logic [31:0] next_periph_first;
    logic [31:0] next_gpio_port;
    logic [31:0] port_write_mask;

    // Writable bits of the port register follow the capability mask
    assign port_write_mask = psr_pkg::MASK_GPIO_PORT & PORT_CAP;

    // Next register values; unwritable bits keep their old value
    always_comb begin
        next_periph_first = periph_first;
        next_gpio_port    = gpio_port_soft_reset;
        if (wr && hit_first) begin
            next_periph_first = req.pwdata & psr_pkg::MASK_PERIPH_FIRST;
        end
        if (wr && hit_port) begin
            next_gpio_port = (gpio_port_soft_reset & ~port_write_mask)
                           | (req.pwdata & port_write_mask);
        end
    end

    // Register state; both clear to zero at reset
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            periph_first         <= psr_pkg::RST_PERIPH_FIRST;
            gpio_port_soft_reset <= psr_pkg::RST_GPIO_PORT;
        end else begin
            periph_first         <= next_periph_first;
            gpio_port_soft_reset <= next_gpio_port;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    // Read mux; reserved bits read zero, unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_first) begin
            rd_mux = periph_first & psr_pkg::MASK_PERIPH_FIRST;
        end else if (hit_port) begin
            rd_mux = gpio_port_soft_reset & psr_pkg::MASK_GPIO_PORT;
        end else if (hit_cap) begin
            rd_mux = PORT_CAP;
        end
    end

    // Combinational read keeps the slave zero-wait
    assign o_prdata = (access && !req.pwrite) ? rd_mux : 32'h0000_0000;

    // ------------------------------------------------------------
    // Reset outputs
    // ------------------------------------------------------------
    // Levels come straight from flops, so they hold until software clears them
    always_comb begin
        o_periph_rst.serial_zero = periph_first[psr_pkg::BIT_SERIAL_ZERO];
        o_periph_rst.serial_one  = periph_first[psr_pkg::BIT_SERIAL_ONE];
        o_periph_rst.sync_serial = periph_first[psr_pkg::BIT_SYNC_SERIAL];
        o_periph_rst.two_wire    = periph_first[psr_pkg::BIT_TWO_WIRE];
        o_periph_rst.timer_zero  = periph_first[psr_pkg::BIT_TIMER_ZERO];
    end

    // One reset level per port; an absent port simply never sees its bit set
    for (genvar g = 0; g < psr_pkg::GPIO_PORTS; g++) begin : g_port_out
        assign o_port_rst[g] = gpio_port_soft_reset[g];
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence port_write_s;
        i_psel && i_penable && i_pwrite && (i_paddr == psr_pkg::OFS_GPIO_PORT);
    endsequence

    property port_masked_p;
        @(posedge i_clk) disable iff (!nrst)
        port_write_s |=> ((gpio_port_soft_reset & ~port_write_mask)
                          == ($past(gpio_port_soft_reset) & ~port_write_mask));
    endproperty

    cap_mask_hold_a: assert property (port_masked_p)
        else $error("Port bit changed without capability");

    port_write_take_a: assert property (@(posedge i_clk) disable iff (!nrst)
        port_write_s |=> ((gpio_port_soft_reset & port_write_mask)
                          == ($past(i_pwdata) & port_write_mask)))
        else $error("Port register write not stored");

    port_read_back_a: assert property (@(posedge i_clk) disable iff (!nrst)
        (i_psel && i_penable && !i_pwrite && i_paddr == psr_pkg::OFS_GPIO_PORT)
        |-> (o_prdata == {27'h0, o_port_rst}))
        else $error("Port readback mismatch");

    first_write_a: assert property (@(posedge i_clk) disable iff (!nrst)
        (i_psel && i_penable && i_pwrite && i_paddr == psr_pkg::OFS_PERIPH_FIRST)
        |=> (o_periph_rst.two_wire == $past(i_pwdata[psr_pkg::BIT_TWO_WIRE])
             && o_periph_rst.timer_zero == $past(i_pwdata[psr_pkg::BIT_TIMER_ZERO])
             && o_periph_rst.sync_serial == $past(i_pwdata[psr_pkg::BIT_SYNC_SERIAL])))
        else $error("First register bit mapping wrong");

    reserved_zero_a: assert property (@(posedge i_clk) disable iff (!nrst)
        gpio_port_soft_reset[31:5] == 27'h0)
        else $error("Reserved port bits not zero");

    hold_reset_a: assert property (@(posedge i_clk) disable iff (!nrst)
        (o_port_rst[0] && !(i_psel && i_penable && i_pwrite
                            && i_paddr == psr_pkg::OFS_GPIO_PORT))
        |=> o_port_rst[0])
        else $error("Port A reset dropped without a write");

    periph_hold_a: assert property (@(posedge i_clk) disable iff (!nrst)
        (o_periph_rst.serial_zero && !(i_psel && i_penable && i_pwrite
                                       && i_paddr == psr_pkg::OFS_PERIPH_FIRST))
        |=> o_periph_rst.serial_zero)
        else $error("Serial reset dropped without a write");

    first_reserved_a: assert property (@(posedge i_clk) disable iff (!nrst)
        (periph_first & ~psr_pkg::MASK_PERIPH_FIRST) == 32'h0)
        else $error("Reserved first-register bits set");

    // ------------------------------------------------------------
    // Bus handshake and decode checks
    // ------------------------------------------------------------
    // Access phase of any transfer
    sequence access_s;
        i_psel && i_penable;
    endsequence

    // Address outside the three mapped words
    sequence unmapped_s;
        (i_paddr != psr_pkg::OFS_PERIPH_FIRST) && (i_paddr != psr_pkg::OFS_GPIO_PORT)
        && (i_paddr != psr_pkg::OFS_PORT_CAP);
    endsequence

    // Read access to the capability word
    sequence cap_read_s;
        i_psel && i_penable && !i_pwrite && (i_paddr == psr_pkg::OFS_PORT_CAP);
    endsequence

    // Write access to the capability word
    sequence cap_write_s;
        i_psel && i_penable && i_pwrite && (i_paddr == psr_pkg::OFS_PORT_CAP);
    endsequence

    // Read access to the first peripheral word
    sequence first_read_s;
        i_psel && i_penable && !i_pwrite && (i_paddr == psr_pkg::OFS_PERIPH_FIRST);
    endsequence

    // Zero-wait slave: a master that waits for ready never stalls
    ready_high_a: assert property (@(posedge i_clk) disable iff (!nrst)
        o_pready)
        else $error("Ready not high");

    unmapped_err_a: assert property (@(posedge i_clk) disable iff (!nrst)
        access_s ##0 unmapped_s |-> o_pslverr)
        else $error("Unmapped access without error");

    mapped_no_err_a: assert property (@(posedge i_clk) disable iff (!nrst)
        !(i_psel && i_penable) || (i_paddr == psr_pkg::OFS_PERIPH_FIRST)
        || (i_paddr == psr_pkg::OFS_GPIO_PORT) || (i_paddr == psr_pkg::OFS_PORT_CAP)
        |-> !o_pslverr)
        else $error("Error flagged on a mapped or idle bus");

    // Read data is zero outside a read access, so stale bits never leak
    read_idle_zero_a: assert property (@(posedge i_clk) disable iff (!nrst)
        !(i_psel && i_penable && !i_pwrite) |-> (o_prdata == 32'h0000_0000))
        else $error("Read data not zero outside a read");

    cap_read_a: assert property (@(posedge i_clk) disable iff (!nrst)
        cap_read_s |-> (o_prdata == PORT_CAP))
        else $error("Capability readback mismatch");

    // Capability word is read-only; a write there must touch nothing
    cap_write_none_a: assert property (@(posedge i_clk) disable iff (!nrst)
        cap_write_s |=> ($stable(gpio_port_soft_reset) && $stable(periph_first)))
        else $error("Capability write changed a register");

    first_read_back_a: assert property (@(posedge i_clk) disable iff (!nrst)
        first_read_s |-> (o_prdata == (periph_first & psr_pkg::MASK_PERIPH_FIRST)))
        else $error("First register readback mismatch");

    first_serial_map_a: assert property (@(posedge i_clk) disable iff (!nrst)
        (i_psel && i_penable && i_pwrite && i_paddr == psr_pkg::OFS_PERIPH_FIRST)
        |=> (o_periph_rst.serial_zero == $past(i_pwdata[psr_pkg::BIT_SERIAL_ZERO])
             && o_periph_rst.serial_one == $past(i_pwdata[psr_pkg::BIT_SERIAL_ONE])))
        else $error("Serial port bit mapping wrong");

    // ------------------------------------------------------------
    // Hold checks
    // ------------------------------------------------------------
    // Without a write to its own word, each register keeps every bit
    port_idle_hold_a: assert property (@(posedge i_clk) disable iff (!nrst)
        !(i_psel && i_penable && i_pwrite && i_paddr == psr_pkg::OFS_GPIO_PORT)
        |=> $stable(gpio_port_soft_reset))
        else $error("Port register changed without a write");

    first_idle_hold_a: assert property (@(posedge i_clk) disable iff (!nrst)
        !(i_psel && i_penable && i_pwrite && i_paddr == psr_pkg::OFS_PERIPH_FIRST)
        |=> $stable(periph_first))
        else $error("First register changed without a write");

    // Ports without capability can never be put into reset
    for (genvar g = 0; g < psr_pkg::GPIO_PORTS; g++) begin : g_absent_chk
        if (!PORT_CAP[g]) begin : g_absent
            absent_port_low_a: assert property (@(posedge i_clk) disable iff (!nrst)
                !o_port_rst[g])
                else $error("Absent port driven into reset");
        end
    end

endmodule : psr_soft_reset

/* shared/psr_pkg.sv */
/*
 * Package for the peripheral soft reset control block: register offsets,
 * field positions, reset values and the packed carriers used by the block.
 * Assumes a 32-bit APB with word-aligned registers.
 */
package psr_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_PERIPH_FIRST = 12'h040;
    localparam logic [11:0] OFS_GPIO_PORT    = 12'h048;
    localparam logic [11:0] OFS_PORT_CAP     = 12'h050;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_SERIAL_ZERO = 0;
    localparam int BIT_SERIAL_ONE  = 1;
    localparam int BIT_SYNC_SERIAL = 4;
    localparam int BIT_TWO_WIRE    = 12;
    localparam int BIT_TIMER_ZERO  = 16;
    localparam int GPIO_PORTS      = 5;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [31:0] RST_PERIPH_FIRST = 32'h0000_0000;
    localparam logic [31:0] RST_GPIO_PORT    = 32'h0000_0000;
    localparam logic [31:0] MASK_PERIPH_FIRST = 32'h0001_1013;
    localparam logic [31:0] MASK_GPIO_PORT    = 32'h0000_001f;
    localparam logic [31:0] RST_PORT_CAP      = 32'h0000_001f;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic timer_zero;
        logic two_wire;
        logic sync_serial;
        logic serial_one;
        logic serial_zero;
    } psr_periph_rst_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } psr_apb_req_t;

endpackage : psr_pkg

/* verification/psr_soft_reset_test.sv */
/*
 * Self-checking bench for the peripheral soft reset register bank.
 * Assumes the design answers APB in the access phase and resets asynchronously.
 */
`timescale 1ns/1ps
module psr_soft_reset_test;
    // ------------------------------------------------------------
    // Signals and design under test
    // ------------------------------------------------------------
    localparam logic [31:0] CAP = 32'h0000_0015; // Ports B and D absent
    logic        i_clk, i_nrst, i_psel, i_penable, i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd, exp_v;
    logic        o_pready, o_pslverr, er;
    psr_pkg::psr_periph_rst_t o_periph_rst;
    logic [4:0]  o_port_rst;
    int          mismatches, checks_done;
    int          pos [5] = '{0, 1, 4, 12, 16};

    psr_soft_reset #(.PORT_CAP(CAP)) DUT (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_periph_rst(o_periph_rst), .o_port_rst(o_port_rst)
    );

    // ------------------------------------------------------------
    // Clock, checks and bus tasks
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", {31'h0, o_pready}, 32'h1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0; i_penable <= 1'b0;
        @(negedge i_clk); // Let register updates land before outputs are looked at
    endtask : apb

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Watchdog: the whole sequence needs well under 1000 cycles
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        mismatches = 0; checks_done = 0;
        i_nrst = 1'b0; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
        i_paddr = 12'h000; i_pwdata = 32'h0000_0000;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        // Reset values of both registers and outputs
        apb(1'b0, psr_pkg::OFS_GPIO_PORT, 32'h0);
        chk("port reg reset", rd, 32'h0000_0000);
        apb(1'b0, psr_pkg::OFS_PERIPH_FIRST, 32'h0);
        chk("first reg reset", rd, 32'h0000_0000);
        chk("outputs reset", {22'h0, o_port_rst, o_periph_rst}, 32'h0);
        // Each port bit with reserved bits set; capability masks absent ports
        for (int i = 0; i < 5; i++) begin
            exp_v = (32'h1 << i) & CAP;
            apb(1'b1, psr_pkg::OFS_GPIO_PORT, 32'hffff_ffe0 | (32'h1 << i));
            chk("port out", {27'h0, o_port_rst}, exp_v);
            apb(1'b0, psr_pkg::OFS_GPIO_PORT, 32'h0);
            chk("port read", rd, exp_v);
        end
        // All ones: only present ports and no reserved bits stick
        apb(1'b1, psr_pkg::OFS_GPIO_PORT, 32'hffff_ffff);
        apb(1'b0, psr_pkg::OFS_GPIO_PORT, 32'h0);
        chk("port all ones", rd, CAP);
        // Each peripheral bit drives its own output
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, psr_pkg::OFS_PERIPH_FIRST, 32'h1 << pos[i]);
            chk("periph out", {27'h0, o_periph_rst}, 32'h1 << i);
            apb(1'b0, psr_pkg::OFS_PERIPH_FIRST, 32'h0);
            chk("periph read", rd, 32'h1 << pos[i]);
        end
        apb(1'b1, psr_pkg::OFS_PERIPH_FIRST, 32'hffff_ffff);
        apb(1'b0, psr_pkg::OFS_PERIPH_FIRST, 32'h0);
        chk("first all ones", rd, 32'h0001_1013);
        // Port resets hold through other traffic until cleared
        chk("port held", {27'h0, o_port_rst}, CAP);
        apb(1'b1, psr_pkg::OFS_GPIO_PORT, 32'h0);
        chk("port cleared", {27'h0, o_port_rst}, 32'h0);
        chk("periph held", {27'h0, o_periph_rst}, 32'h1f);
        // Capability register is read-only; unmapped place refused
        apb(1'b1, psr_pkg::OFS_PORT_CAP, 32'h0);
        apb(1'b0, psr_pkg::OFS_PORT_CAP, 32'h0);
        chk("cap read", rd, CAP);
        apb(1'b1, 12'h0fc, 32'hffff_ffff);
        chk("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped read", rd, 32'h0);
        chk("unmapped err rd", {31'h0, er}, 32'h1);
        // Mid-run reset clears held bits at once
        apb(1'b1, psr_pkg::OFS_GPIO_PORT, 32'h1);
        i_nrst <= 1'b0;
        @(negedge i_clk);
        chk("mid reset out", {22'h0, o_port_rst, o_periph_rst}, 32'h0);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        apb(1'b0, psr_pkg::OFS_PERIPH_FIRST, 32'h0);
        chk("first after reset", rd, 32'h0);
        report_and_stop();
    end
endmodule : psr_soft_reset_test
